// ---- core/flsr_dev.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "flsr_regs.svh"
module flsr_dev
    import flsr_pkg::*;
#(
    parameter int PROG_CYCLES =
        (`FLSR_PROG_MIN_NS + `FLSR_CLK_NS - 1) / `FLSR_CLK_NS,
    // Identification values are arbitrary
    parameter logic [7:0] SIG_BYTE1 = 8'h5a,
    parameter logic [7:0] SIG_BYTE2 = 8'h3c,
    parameter logic [7:0] SIG_BYTE3 = 8'h96,
    parameter logic [14:0] RWW_WORD_LIMIT = 15'h1c00
) (
    input wire logic core_clk,
    input wire logic rstn,
    flsr_if.dev bus,
    input wire logic [7:0] fuse_low_prog,
    input wire logic [7:0] fuse_high_prog,
    input wire logic [7:0] ext_fuse_prog,
    input wire logic [7:0] lock_prog,
    input wire logic [7:0] osc_cal,
    input wire logic eeprom_busy,
    output logic [15:0] flash_raddr,
    input wire logic [7:0] flash_rdata,
    output logic flash_op_start,
    output flsr_op_t flash_op,
    output logic [15:0] flash_op_addr,
    output logic lock_wr,
    output logic [7:0] lock_wr_data
);

    // ****************************************
    // Arming state
    // ****************************************
    logic armed;
    logic sel_cfg;
    logic sel_sig;
    logic sel_page_erase_select;
    logic sel_page_write_select;
    logic sel_rww_read_reenable;
    logic [2:0] win;
    logic lpm_hit;
    logic spm_hit;
    logic expire;
    logic prog_busy;
    logic prog_rww;
    logic [19:0] prog_cnt;
    logic rww_busy;
    logic [7:0] next_rdata;
    logic start_prog;
    logic ptr_in_rww;

    assign ptr_in_rww = bus.ptr[15:1] < RWW_WORD_LIMIT;

    assign lpm_hit = armed && bus.lpm_req && (sel_cfg || sel_sig)
        && (win < `FLSR_LPM_WIN); // RULE21
    assign spm_hit = armed && bus.spm_exec && !sel_sig
        && (win < `FLSR_SPM_WIN); // RULE20

    // Signature mode has no store partner, so it times out sooner
    always_comb begin
        if (sel_sig) begin
            expire = (win == `FLSR_LPM_WIN - 3'h1); // RULE9
        end else begin
            expire = (win == `FLSR_SPM_WIN - 3'h1); // RULE2
        end
    end

    // EEPROM activity and a running operation both lock out arming
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            armed <= 1'b0;
            sel_cfg <= 1'b0;
            sel_sig <= 1'b0;
            sel_page_erase_select <= 1'b0;
            sel_page_write_select <= 1'b0;
            sel_rww_read_reenable <= 1'b0;
            win <= 3'h0;
        end else if (bus.ctrl_wr && !armed && !prog_busy && !eeprom_busy)
        begin
            armed <= bus.ctrl_wdata[`FLSR_BIT_STORE_PROG_ENABLE];
            sel_cfg <= bus.ctrl_wdata[`FLSR_BIT_BLB];
            sel_sig <= bus.ctrl_wdata[`FLSR_BIT_SIG];
            sel_page_erase_select <= bus.ctrl_wdata[`FLSR_BIT_PAGE_ERASE_SELECT];
            sel_page_write_select <= bus.ctrl_wdata[`FLSR_BIT_PAGE_WRITE_SELECT];
            sel_rww_read_reenable <= bus.ctrl_wdata[`FLSR_BIT_RWW_READ_REENABLE];
            win <= 3'h0; // RULE21
        end else if (armed) begin
            if (lpm_hit || spm_hit || expire) begin
                armed <= 1'b0; // RULE2 RULE9
                sel_cfg <= 1'b0;
                sel_sig <= 1'b0;
                sel_page_erase_select <= 1'b0;
                sel_page_write_select <= 1'b0;
                sel_rww_read_reenable <= 1'b0;
                win <= 3'h0;
            end else begin
                win <= win + 3'h1;
            end
        end else if (!armed) begin
            sel_cfg <= 1'b0;
            sel_sig <= 1'b0;
            sel_page_erase_select <= 1'b0;
            sel_page_write_select <= 1'b0;
            sel_rww_read_reenable <= 1'b0;
        end
    end

    // ****************************************
    // Programming timer
    // ****************************************
    assign start_prog = rstn && spm_hit
        && (sel_page_erase_select || sel_page_write_select || sel_cfg);

    // A running write ignores reset so the cells are never half done
    // Busy is tested first so an unknown power-up value still resets
    always_ff @(posedge core_clk) begin
        if (prog_busy) begin
            if (prog_cnt == 20'(PROG_CYCLES - 1)) begin
                prog_busy <= 1'b0; // RULE13
                prog_cnt <= 20'h0;
                flash_op <= FLSR_OP_NONE;
            end else begin
                prog_cnt <= prog_cnt + 20'h1;
            end
        end else if (!rstn) begin
            prog_busy <= 1'b0; // RULE12
            prog_cnt <= 20'h0;
            prog_rww <= 1'b0;
            flash_op <= FLSR_OP_NONE;
            flash_op_addr <= 16'h0;
            lock_wr_data <= 8'h0;
        end else if (start_prog) begin
            prog_busy <= 1'b1;
            prog_cnt <= 20'h0;
            flash_op_addr <= bus.ptr;
            lock_wr_data <= ~bus.spm_r0 & `FLSR_LOCK_PROG_MASK; // RULE20
            if (sel_page_erase_select) begin
                flash_op <= FLSR_OP_ERASE;
                prog_rww <= ptr_in_rww;
            end else if (sel_page_write_select) begin
                flash_op <= FLSR_OP_WRITE;
                prog_rww <= ptr_in_rww;
            end else begin
                flash_op <= FLSR_OP_LOCK;
                prog_rww <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            flash_op_start <= 1'b0;
        end else begin
            flash_op_start <= start_prog;
        end
    end

    // Commit pulse must survive a reset that lands mid-write
    always_ff @(posedge core_clk) begin
        lock_wr <= prog_busy && (flash_op == FLSR_OP_LOCK)
            && (prog_cnt == 20'(PROG_CYCLES - 1)); // RULE12
    end

    // ****************************************
    // Section busy flag
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (start_prog && (sel_page_erase_select || sel_page_write_select)
            && ptr_in_rww) begin
            rww_busy <= 1'b1; // RULE19
        end else if (prog_busy && prog_rww) begin
            rww_busy <= 1'b1; // RULE12 RULE19
        end else if (!rstn) begin
            rww_busy <= 1'b0;
        end else if (spm_hit && sel_rww_read_reenable) begin
            rww_busy <= 1'b0; // RULE19
        end
    end

    // Lock writes leave the whole array readable
    assign bus.cpu_halt = prog_busy && !prog_rww
        && (flash_op != FLSR_OP_LOCK); // RULE14
    assign bus.eeprom_write_pending = eeprom_busy;

    always_comb begin
        bus.ctrl_rdata = 8'h0;
        bus.ctrl_rdata[`FLSR_BIT_STORE_PROG_ENABLE] = armed || prog_busy; // RULE15
        bus.ctrl_rdata[`FLSR_BIT_PAGE_ERASE_SELECT] = sel_page_erase_select
            || (flash_op == FLSR_OP_ERASE);
        bus.ctrl_rdata[`FLSR_BIT_PAGE_WRITE_SELECT] = sel_page_write_select
            || (flash_op == FLSR_OP_WRITE);
        bus.ctrl_rdata[`FLSR_BIT_BLB] = sel_cfg
            || (flash_op == FLSR_OP_LOCK);
        bus.ctrl_rdata[`FLSR_BIT_SIG] = sel_sig;
        bus.ctrl_rdata[`FLSR_BIT_RWW_BUSY_FLAG] = rww_busy; // RULE19
    end

    // ****************************************
    // Load data path
    // ****************************************
    function automatic logic [7:0] cfg_byte(input logic [15:0] a);
        logic [7:0] r;
        r = `FLSR_RESERVED_BYTE; // RULE22
        unique case (a)
            `FLSR_ADDR_FUSE_LOW: r = ~fuse_low_prog; // RULE4 RULE7
            `FLSR_ADDR_LOCK: r = ~lock_prog; // RULE1 RULE7
            `FLSR_ADDR_EXT_FUSE: r = ~ext_fuse_prog; // RULE6 RULE7
            `FLSR_ADDR_FUSE_HIGH: r = ~fuse_high_prog; // RULE5 RULE7
            default: r = `FLSR_RESERVED_BYTE; // RULE22
        endcase
        return r;
    endfunction : cfg_byte

    function automatic logic [7:0] sig_byte(input logic [15:0] a);
        logic [7:0] r;
        r = `FLSR_RESERVED_BYTE;
        unique case (a)
            `FLSR_ADDR_SIG1: r = SIG_BYTE1; // RULE10
            `FLSR_ADDR_SIG2: r = SIG_BYTE2; // RULE10
            `FLSR_ADDR_SIG3: r = SIG_BYTE3; // RULE10
            `FLSR_ADDR_CAL: r = osc_cal; // RULE11
            default: r = `FLSR_RESERVED_BYTE; // RULE11 RULE22
        endcase
        return r;
    endfunction : sig_byte

    assign flash_raddr = bus.ptr;

    always_comb begin
        if (lpm_hit && sel_sig) begin
            next_rdata = sig_byte(bus.ptr); // RULE8
        end else if (lpm_hit) begin
            next_rdata = cfg_byte(bus.ptr); // RULE1
        end else if (rww_busy && ptr_in_rww) begin
            next_rdata = `FLSR_RESERVED_BYTE; // RULE14
        end else begin
            next_rdata = flash_rdata; // RULE3
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            bus.lpm_valid <= 1'b0;
            bus.lpm_rdata <= 8'h0;
        end else begin
            bus.lpm_valid <= bus.lpm_req;
            if (bus.lpm_req) begin
                bus.lpm_rdata <= next_rdata;
            end
        end
    end

endmodule : flsr_dev
`default_nettype wire

// ---- core/flsr_host.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "flsr_regs.svh"
module flsr_host
    import flsr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    flsr_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire flsr_cmd_t cmd_op,
    input wire logic [15:0] cmd_ptr,
    input wire logic [7:0] cmd_data,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic irq_block
);

    // ****************************************
    // Command sequencer
    // ****************************************
    flsr_hstate_t state;
    flsr_cmd_t op;
    logic [7:0] pattern;
    logic [7:0] next_pattern;
    logic is_read;

    assign is_read = (op == FLSR_CMD_LOCK_RD) || (op == FLSR_CMD_SIG_RD)
        || (op == FLSR_CMD_FUSE_LOW_RD) || (op == FLSR_CMD_FUSE_HIGH_RD)
        || (op == FLSR_CMD_EXT_FUSE_RD);

    always_comb begin
        next_pattern = 8'h0;
        next_pattern[`FLSR_BIT_STORE_PROG_ENABLE] = 1'b1;
        unique case (cmd_op)
            FLSR_CMD_SIG_RD: next_pattern[`FLSR_BIT_SIG] = 1'b1; // RULE8
            FLSR_CMD_PAGE_ERASE: next_pattern[`FLSR_BIT_PAGE_ERASE_SELECT] = 1'b1;
            FLSR_CMD_PAGE_WRITE: next_pattern[`FLSR_BIT_PAGE_WRITE_SELECT] = 1'b1;
            FLSR_CMD_RWW_REENABLE: next_pattern[`FLSR_BIT_RWW_READ_REENABLE] = 1'b1;
            default: next_pattern[`FLSR_BIT_BLB] = 1'b1; // RULE1 RULE20
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state <= FLSR_H_IDLE;
            op <= FLSR_CMD_LOCK_RD;
            pattern <= 8'h0;
            bus.ptr <= 16'h0;
            bus.spm_r0 <= 8'h0;
        end else begin
            unique case (state)
                FLSR_H_IDLE: if (cmd_valid) begin
                    op <= cmd_op;
                    pattern <= next_pattern;
                    bus.spm_r0 <= cmd_data;
                    unique case (cmd_op)
                        FLSR_CMD_LOCK_RD: bus.ptr <= `FLSR_ADDR_LOCK; // RULE1
                        FLSR_CMD_LOCK_WR: bus.ptr <= `FLSR_ADDR_LOCK;
                        FLSR_CMD_FUSE_LOW_RD:
                            bus.ptr <= `FLSR_ADDR_FUSE_LOW; // RULE4
                        FLSR_CMD_FUSE_HIGH_RD:
                            bus.ptr <= `FLSR_ADDR_FUSE_HIGH; // RULE5
                        FLSR_CMD_EXT_FUSE_RD:
                            bus.ptr <= `FLSR_ADDR_EXT_FUSE; // RULE6
                        default: bus.ptr <= cmd_ptr;
                    endcase
                    state <= FLSR_H_POLL;
                end
                FLSR_H_POLL: if (!bus.ctrl_rdata[`FLSR_BIT_STORE_PROG_ENABLE]) begin
                    state <= FLSR_H_EEWAIT; // RULE15
                end
                FLSR_H_EEWAIT: if (!bus.eeprom_write_pending) begin
                    state <= FLSR_H_WRITE; // RULE16
                end
                FLSR_H_WRITE: state <= FLSR_H_ISSUE;
                FLSR_H_ISSUE: begin
                    if (is_read) begin
                        state <= FLSR_H_WAIT;
                    end else if (op == FLSR_CMD_RWW_REENABLE) begin
                        state <= FLSR_H_RWWCHK;
                    end else begin
                        state <= FLSR_H_RESP;
                    end
                end
                FLSR_H_WAIT: if (bus.lpm_valid) begin
                    state <= FLSR_H_RESP;
                end
                // Repeat until the section is free again
                FLSR_H_RWWCHK: if (bus.ctrl_rdata[`FLSR_BIT_RWW_BUSY_FLAG]) begin
                    state <= FLSR_H_POLL; // RULE17
                end else begin
                    state <= FLSR_H_RESP;
                end
                FLSR_H_RESP: state <= FLSR_H_IDLE;
            endcase
        end
    end

    // ****************************************
    // Answer register
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rsp_data <= 8'h0;
        end else if (state == FLSR_H_WAIT && bus.lpm_valid) begin
            rsp_data <= bus.lpm_rdata;
        end else if (state == FLSR_H_ISSUE && !is_read) begin
            rsp_data <= 8'h0;
        end
    end

    // Load or store goes out in the cycle right after the write
    assign bus.ctrl_wr = (state == FLSR_H_WRITE); // RULE16
    assign bus.ctrl_wdata = pattern;
    assign bus.lpm_req = (state == FLSR_H_ISSUE) && is_read; // RULE1 RULE8
    assign bus.spm_exec = (state == FLSR_H_ISSUE) && !is_read; // RULE20
    assign irq_block = (state == FLSR_H_EEWAIT) || (state == FLSR_H_WRITE)
        || (state == FLSR_H_ISSUE); // RULE16
    assign cmd_ready = (state == FLSR_H_IDLE);
    assign rsp_valid = (state == FLSR_H_RESP);

endmodule : flsr_host
`default_nettype wire

// ---- dv/flsr_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module flsr_asserts (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic [7:0] ctrl_rdata,
    input wire logic spm_exec,
    input wire logic lpm_req,
    input wire logic lpm_valid,
    input wire logic eeprom_write_pending,
    input wire logic cpu_halt
);
    // ****
    // Accepted arming write
    // ****
    logic arm_ok;
    assign arm_ok = ctrl_wr && ctrl_wdata[0] && !ctrl_rdata[0] &&
        !eeprom_write_pending;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    a_arm_shows: assert property (arm_ok |=> ctrl_rdata[0])
        else $error("arming not visible");
    a_lpm_answer: assert property (lpm_req |=> lpm_valid)
        else $error("load not answered");
    a_lpm_quiet: assert property (!lpm_req |=> !lpm_valid)
        else $error("answer without load");
    a_read_clears: assert property (lpm_req && ctrl_rdata[0] &&
        (ctrl_rdata[3] || ctrl_rdata[5]) |=> !ctrl_rdata[0])
        else $error("readback left armed");
    a_fuse_expire: assert property (arm_ok && ctrl_wdata[3] ##1
        (!lpm_req && !spm_exec) [*4] |=> !ctrl_rdata[0])
        else $error("fuse window not expired");
    a_sig_expire: assert property (arm_ok && ctrl_wdata[5] ##1
        !lpm_req [*3] |=> !ctrl_rdata[5])
        else $error("signature window not expired");
    a_wr_idle: assert property (ctrl_wr |-> !ctrl_rdata[0])
        else $error("write while enable set");
    a_no_wr_pending: assert property (ctrl_wr |->
        !eeprom_write_pending)
        else $error("write while eeprom busy");
    a_busy_holds: assert property (ctrl_rdata[6] && !spm_exec
        |=> ctrl_rdata[6])
        else $error("busy flag dropped");
    a_halt_prog: assert property (cpu_halt |-> ctrl_rdata[0])
        else $error("halt without operation");
endmodule : flsr_asserts
`default_nettype wire

// ---- dv/flsr_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module flsr_tb;
    import flsr_pkg::*;
    // ****
    // Setup
    // ****
    localparam int PROG = 8;
    // Identification values are arbitrary
    localparam logic [7:0] S1 = 8'h11, S2 = 8'h22, S3 = 8'h33;
    localparam logic [7:0] FL = 8'h0f, FH = 8'h81, FE = 8'h02;
    localparam logic [7:0] LK = 8'h24, CAL = 8'ha7;
    typedef struct {
        flsr_cmd_t op;
        logic [15:0] p;
        logic [7:0] e;
    } flsr_row_t;
    flsr_row_t rows [11] = '{
        '{FLSR_CMD_LOCK_RD, 16'h0001, ~LK},
        '{FLSR_CMD_FUSE_LOW_RD, 16'h0000, ~FL},
        '{FLSR_CMD_FUSE_HIGH_RD, 16'h0003, ~FH},
        '{FLSR_CMD_EXT_FUSE_RD, 16'h0002, ~FE},
        '{FLSR_CMD_SIG_RD, 16'h0005, 8'hff},
        '{FLSR_CMD_SIG_RD, 16'h0000, S1},
        '{FLSR_CMD_SIG_RD, 16'h0002, S2},
        '{FLSR_CMD_SIG_RD, 16'h0004, S3},
        '{FLSR_CMD_SIG_RD, 16'h0001, CAL},
        '{FLSR_CMD_SIG_RD, 16'h0003, 8'hff},
        '{FLSR_CMD_SIG_RD, 16'h0006, 8'hff}
    };
    logic core_clk, rstn, cmd_valid, eeprom_busy, cmd_ready, rsp_valid;
    logic irq_block, flash_op_start, lock_wr;
    flsr_cmd_t cmd_op;
    flsr_op_t flash_op;
    logic [15:0] cmd_ptr, flash_raddr, flash_op_addr;
    logic [7:0] cmd_data, rsp_data, lock_wr_data, flash_rdata;
    int bad_count = 0, total_checks = 0, n;

    // Flash content follows the address so stale reads show up
    assign flash_rdata = flash_raddr[7:0] ^ 8'h5a;

    flsr_if flsr_if_i ();
    flsr_dev #(.PROG_CYCLES(PROG), .SIG_BYTE1(S1), .SIG_BYTE2(S2),
        .SIG_BYTE3(S3)) flsr_dev_i (
        .core_clk(core_clk), .rstn(rstn), .bus(flsr_if_i),
        .fuse_low_prog(FL), .fuse_high_prog(FH), .ext_fuse_prog(FE),
        .lock_prog(LK), .osc_cal(CAL), .eeprom_busy(eeprom_busy),
        .flash_raddr(flash_raddr), .flash_rdata(flash_rdata),
        .flash_op_start(flash_op_start), .flash_op(flash_op),
        .flash_op_addr(flash_op_addr), .lock_wr(lock_wr),
        .lock_wr_data(lock_wr_data)
    );
    flsr_host flsr_host_i (
        .core_clk(core_clk), .rstn(rstn), .bus(flsr_if_i),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_ptr(cmd_ptr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .irq_block(irq_block)
    );
    flsr_asserts flsr_asserts_i (
        .core_clk(core_clk), .rstn(rstn), .ctrl_wr(flsr_if_i.ctrl_wr),
        .ctrl_wdata(flsr_if_i.ctrl_wdata),
        .ctrl_rdata(flsr_if_i.ctrl_rdata), .spm_exec(flsr_if_i.spm_exec),
        .lpm_req(flsr_if_i.lpm_req), .lpm_valid(flsr_if_i.lpm_valid),
        .eeprom_write_pending(flsr_if_i.eeprom_write_pending),
        .cpu_halt(flsr_if_i.cpu_halt)
    );

    // ****
    // Tasks
    // ****
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t flag %b exp %b", $time, got, exp);
        end
    endtask : chk1
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t byte %h exp %h", $time, got, exp);
        end
    endtask : chk8
    task automatic run_cmd(input flsr_cmd_t op, input logic [15:0] p,
        input logic [7:0] dat);
        int k;
        k = 0;
        cmd_op <= op;
        cmd_ptr <= p;
        cmd_data <= dat;
        cmd_valid <= 1'b1;
        do begin
            @(posedge core_clk);
            k++;
        end while (cmd_ready !== 1'b1 && k < 60);
        cmd_valid <= 1'b0;
    endtask : run_cmd
    // Bounded wait; the cycle count is left in n
    task automatic wait_hi(ref logic s);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (s !== 1'b1 && n < 60);
    endtask : wait_hi
    task automatic results;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end

    // ****
    // Sequence
    // ****
    initial begin
        rstn = 1'b0;
        cmd_valid = 1'b0;
        eeprom_busy = 1'b0;
        cmd_op = FLSR_CMD_LOCK_RD;
        cmd_ptr = 16'h0000;
        cmd_data = 8'h00;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        chk1(cmd_ready, 1'b1);
        chk8(flsr_if_i.ctrl_rdata, 8'h00);
        chk1(flsr_if_i.lpm_valid, 1'b0);
        // Back-to-back readback table
        foreach (rows[i]) begin
            run_cmd(rows[i].op, rows[i].p, 8'h00);
            wait_hi(rsp_valid);
            chk8(rsp_data, rows[i].e);
            chk1(flsr_if_i.ctrl_rdata[0], 1'b0);
        end
        // Eeprom write holds off arming
        eeprom_busy <= 1'b1;
        run_cmd(FLSR_CMD_LOCK_RD, 16'h0001, 8'h00);
        repeat (10) @(posedge core_clk);
        chk1(irq_block, 1'b1);
        chk1(rsp_valid, 1'b0);
        eeprom_busy <= 1'b0;
        wait_hi(rsp_valid);
        chk8(rsp_data, ~LK);
        // Lock write survives a reset in mid-operation
        run_cmd(FLSR_CMD_LOCK_WR, 16'h0001, 8'hc5);
        wait_hi(flash_op_start);
        chk1(flash_op === FLSR_OP_LOCK, 1'b1);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk1(flash_op === FLSR_OP_LOCK, 1'b1);
        rstn <= 1'b1;
        wait_hi(lock_wr);
        chk1(n + 2 >= PROG && n <= PROG, 1'b1);
        chk8(lock_wr_data, ~8'hc5 & 8'h3f);
        // Erase on the halting region, then write on the shared one
        run_cmd(FLSR_CMD_PAGE_ERASE, 16'h3800, 8'h00);
        wait_hi(flash_op_start);
        @(posedge core_clk);
        chk1(flsr_if_i.cpu_halt, 1'b1);
        run_cmd(FLSR_CMD_PAGE_WRITE, 16'h0100, 8'h00);
        wait_hi(flash_op_start);
        @(posedge core_clk);
        chk1(flash_op === FLSR_OP_WRITE, 1'b1);
        chk8(flash_op_addr[7:0], 8'h00);
        chk1(flsr_if_i.cpu_halt, 1'b0);
        chk1(flsr_if_i.ctrl_rdata[6], 1'b1);
        repeat (PROG + 4) @(posedge core_clk);
        chk1(flsr_if_i.ctrl_rdata[6], 1'b1);
        run_cmd(FLSR_CMD_RWW_REENABLE, 16'h0000, 8'h00);
        wait_hi(cmd_ready);
        chk1(flsr_if_i.ctrl_rdata[6], 1'b0);
        run_cmd(FLSR_CMD_SIG_RD, 16'h0001, 8'h00);
        wait_hi(rsp_valid);
        chk8(rsp_data, CAL);
        results();
    end
endmodule : flsr_tb
`default_nettype wire

// ---- inc/flsr_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface flsr_if;
    logic ctrl_wr;
    logic [7:0] ctrl_wdata;
    logic [7:0] ctrl_rdata;
    logic spm_exec;
    logic [7:0] spm_r0;
    logic lpm_req;
    logic [15:0] ptr;
    logic lpm_valid;
    logic [7:0] lpm_rdata;
    logic eeprom_write_pending;
    logic cpu_halt;

    modport dev (
        input ctrl_wr, ctrl_wdata, spm_exec, spm_r0, lpm_req, ptr,
        output ctrl_rdata, lpm_valid, lpm_rdata, eeprom_write_pending,
        output cpu_halt
    );
    modport host (
        output ctrl_wr, ctrl_wdata, spm_exec, spm_r0, lpm_req, ptr,
        input ctrl_rdata, lpm_valid, lpm_rdata, eeprom_write_pending,
        input cpu_halt
    );
endinterface : flsr_if
`default_nettype wire

// ---- inc/flsr_pkg.sv ----
package flsr_pkg;

    typedef enum logic [1:0] {
        FLSR_OP_NONE,
        FLSR_OP_ERASE,
        FLSR_OP_WRITE,
        FLSR_OP_LOCK
    } flsr_op_t;

    typedef enum logic [3:0] {
        FLSR_CMD_LOCK_RD,
        FLSR_CMD_FUSE_LOW_RD,
        FLSR_CMD_FUSE_HIGH_RD,
        FLSR_CMD_EXT_FUSE_RD,
        FLSR_CMD_SIG_RD,
        FLSR_CMD_LOCK_WR,
        FLSR_CMD_PAGE_ERASE,
        FLSR_CMD_PAGE_WRITE,
        FLSR_CMD_RWW_REENABLE
    } flsr_cmd_t;

    typedef enum logic [2:0] {
        FLSR_H_IDLE,
        FLSR_H_POLL,
        FLSR_H_EEWAIT,
        FLSR_H_WRITE,
        FLSR_H_ISSUE,
        FLSR_H_WAIT,
        FLSR_H_RWWCHK,
        FLSR_H_RESP
    } flsr_hstate_t;

endpackage : flsr_pkg

// ---- inc/flsr_regs.svh ----
// Operation
// RULE1 - Pointer 0x0001 plus armed read returns lock bits
// RULE2 - Select and enable bits clear themselves automatically
// RULE3 - Disarmed load performs ordinary flash read
// RULE4 - Pointer 0x0000 returns fuse low byte
// RULE5 - Pointer 0x0003 returns fuse high byte
// RULE6 - Pointer 0x0002 returns extended fuse byte
// RULE7 - Programmed bits read zero, unprogrammed read one
// RULE8 - Signature mode load returns addressed row byte
// RULE9 - Signature mode clears after read or timeout
// RULE10 - Identification bytes sit at 0x0000, 0x0002, 0x0004
// RULE11 - Calibration byte at 0x0001, others reserved
// RULE12 - Reset does not abort a running write
// RULE13 - Each flash write lasts 3.7 to 4.5 ms
// RULE14 - During erase or write only safe region fetchable
// RULE15 - Software polls enable bit clear before commanding
// RULE16 - Software waits EEPROM idle, masks interrupts
// RULE17 - Software repeats re-enable while busy flag set
// RULE18 - Program boot lock bits when no updates needed
// RULE19 - Busy flag holds while section is busy
// RULE20 - Lock write pattern X0001001, store within four
// RULE21 - Window counts from cycle after control write
// RULE22 - Reserved readback address returns all ones
`ifndef FLSR_REGS_SVH
`define FLSR_REGS_SVH

// ****************************************
// Control and status bit positions
// ****************************************
`define FLSR_BIT_STORE_PROG_ENABLE 0
`define FLSR_BIT_PAGE_ERASE_SELECT 1
`define FLSR_BIT_PAGE_WRITE_SELECT 2
`define FLSR_BIT_BLB 3
`define FLSR_BIT_RWW_READ_REENABLE 4
`define FLSR_BIT_SIG 5
`define FLSR_BIT_RWW_BUSY_FLAG 6

// ****************************************
// Readback addresses
// ****************************************
`define FLSR_ADDR_FUSE_LOW 16'h0000
`define FLSR_ADDR_LOCK 16'h0001
`define FLSR_ADDR_EXT_FUSE 16'h0002
`define FLSR_ADDR_FUSE_HIGH 16'h0003
`define FLSR_ADDR_SIG1 16'h0000
`define FLSR_ADDR_CAL 16'h0001
`define FLSR_ADDR_SIG2 16'h0002
`define FLSR_ADDR_SIG3 16'h0004
`define FLSR_RESERVED_BYTE 8'hff
`define FLSR_LOCK_PROG_MASK 8'h3f

// ****************************************
// Timing
// ****************************************
`define FLSR_LPM_WIN 3'h3
`define FLSR_SPM_WIN 3'h4
`define FLSR_CLK_NS 50
`define FLSR_PROG_MIN_NS 3700000
`define FLSR_PROG_MAX_NS 4500000

`endif
